// ===== rtl/rnes_pkg.sv
// ============================================================
// Shared constants and carriers
package rnes_pkg;

    // ========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ_DEF     = 50_000_000;
    localparam int unsigned OSC_MAX_HZ     = 5_000_000;
    localparam int unsigned SYNC_MIN_RATIO = 8;
    localparam int unsigned OSC_DIV        = 4;
    localparam logic [1:0]  OSC_CNT_E_HI   = 2'h2;
    localparam logic [1:0]  RST_MIN_BUSCYC = 2'h3;

    // ========================================================
    // Vectors and stacking
    localparam logic [15:0] VEC_RESET      = 16'hFFFE;
    localparam logic [15:0] VEC_NMI        = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ        = 16'hFFF8;
    localparam logic [15:0] VEC_LO_STEP    = 16'h0001;
    localparam logic [7:0]  ADDR_HI_FORCE  = 8'hFF;
    localparam logic [2:0]  STACK_BYTES    = 3'h7;
    localparam logic [15:0] STACK_BYTES_W  = 16'h0007;

    // ========================================================
    // Register map, byte addresses
    localparam int unsigned AV_ADDR_W      = 8;
    localparam logic [7:0]  REG_RAM_CTRL   = 8'h14;
    localparam logic [7:0]  REG_STATUS     = 8'h18;
    localparam logic [7:0]  REG_CONTROL    = 8'h1C;
    localparam int unsigned RAM_E_BIT      = 6;
    localparam logic [7:0]  RAM_CTRL_RESET = 8'h40;
    localparam int unsigned CTL_MASK_CLR   = 0;
    localparam int unsigned CTL_MASK_SET   = 1;
    localparam int unsigned ST_MASK_BIT    = 0;
    localparam int unsigned ST_NMI_BIT     = 1;
    localparam int unsigned ST_BUSY_BIT    = 2;
    localparam int unsigned ST_CFG_LSB     = 4;
    localparam int unsigned ST_LOST_BIT    = 7;

    // ========================================================
    // Standby RAM
    localparam int unsigned RAM_BYTES      = 128;
    localparam int unsigned RAM_AW         = 7;
    localparam int unsigned RAM_KEEP_BYTES = 64;

    // ========================================================
    // Pin synchroniser lanes
    localparam int unsigned PIN_N          = 7;
    localparam int unsigned PIN_OSC        = 0;
    localparam int unsigned PIN_CFG0       = 1;
    localparam int unsigned PIN_CFG1       = 2;
    localparam int unsigned PIN_CFG2       = 3;
    localparam int unsigned PIN_CLR        = 4;
    localparam int unsigned PIN_NMI        = 5;
    localparam int unsigned PIN_IRQ        = 6;

    typedef enum logic [5:0] {
        ST_RUN    = 6'b000001,
        ST_HOLD   = 6'b000010,
        ST_STACK  = 6'b000100,
        ST_VEC_HI = 6'b001000,
        ST_VEC_LO = 6'b010000,
        ST_SPARE  = 6'b100000
    } rnes_state_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] x;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  ccr;
        logic [15:0] sp;
    } rnes_cpu_regs_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
        logic        read;
    } rnes_bus_t;

endpackage : rnes_pkg

// ===== rtl/rnes_sequencer.sv
`timescale 1ns/1ps
// How it works
// - Bus clock is oscillator divided by four.
// - Divide any oscillator input up to 5 MHz.
// - On release force upper address lines high.
// - On release latch three boot configuration pins.
// - Reset vector fetched from FFFE then FFFF.
// - Reset sets mask; maskable requests ignored meanwhile.
// - Falling edge of nmi_n requests service.
// - Finish current instruction before taking interrupt.
// - Mask never blocks or delays nmi service.
// - Stack PC, X, both accumulators, CCR.
// - Nmi vector fetched from FFFC then FFFD.
// - Sample on E, start next bus cycle.
// - Cleared RAM enable blocks standby RAM access.
// - Only lowest 64 bytes survive power down.
// - Level irq stacks, sets mask, vectors FFF8.
module rnes_sequencer #(
    parameter int unsigned CLK_HZ = rnes_pkg::CLK_HZ_DEF
) (
    // Clock and reset
    input  wire logic                                clock,
    input  wire logic                                reset,
    // Pins
    input  wire logic                                osc_input,
    input  wire logic                                chip_clear_in_n,
    input  wire logic                                nmi_n,
    input  wire logic                                irq_n,
    input  wire logic                                boot_config_bit2,
    input  wire logic                                boot_config_bit1,
    input  wire logic                                boot_config_bit0,
    output logic                                     e_clock_q,
    // Core side
    input  wire logic                                instr_done,
    input  wire rnes_pkg::rnes_cpu_regs_t            cpu_regs,
    input  wire logic [7:0]                          bus_rdata,
    output rnes_pkg::rnes_bus_t                      bus_q,
    output logic                                     seq_busy_q,
    output logic                                     pc_load_q,
    output logic [15:0]                              pc_value_q,
    output logic                                     sp_load_q,
    output logic [15:0]                              sp_value_q,
    output logic                                     irq_mask_q,
    output logic [2:0]                               boot_cfg_q,
    // Standby RAM port
    input  wire logic                                standby_power_down,
    input  wire logic                                ram_req,
    input  wire logic                                ram_we,
    input  wire logic [rnes_pkg::RAM_AW-1:0]         ram_addr,
    input  wire logic [7:0]                          ram_wdata,
    output logic [7:0]                               ram_rdata,
    output logic                                     ram_ok_q,
    // Avalon-MM slave
    input  wire logic [rnes_pkg::AV_ADDR_W-1:0]      avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [31:0]                         avs_writedata,
    output logic [31:0]                              avs_readdata_q,
    output logic                                     avs_waitrequest_q
);
    // ========================================================
    // Elaboration checks
    if (CLK_HZ / rnes_pkg::OSC_MAX_HZ < rnes_pkg::SYNC_MIN_RATIO) begin : g_bad_clk
        $error("clock too slow to sample the oscillator pin");
    end

    // ========================================================
    // Pin synchronisers, three stages, change taken when 2 and 3 agree
    logic [rnes_pkg::PIN_N-1:0] pin_raw;
    logic [rnes_pkg::PIN_N-1:0] pin_lvl;
    logic [rnes_pkg::PIN_N-1:0] pin_lvl_d;

    assign pin_raw = {irq_n, nmi_n, chip_clear_in_n, boot_config_bit2,
                      boot_config_bit1, boot_config_bit0, osc_input};

    for (genvar i = 0; i < rnes_pkg::PIN_N; i++) begin : g_sync
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic lvl_q;
        logic lvl_d;
        always_comb begin
            lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
        end
        always_ff @(posedge clock) begin
            if (reset) begin
                s1_q  <= 1'b1;
                s2_q  <= 1'b1;
                s3_q  <= 1'b1;
                lvl_q <= 1'b1;
            end else begin
                s1_q  <= pin_raw[i];
                s2_q  <= s1_q;
                s3_q  <= s2_q;
                lvl_q <= lvl_d;
            end
        end
        assign pin_lvl[i]   = lvl_q;
        assign pin_lvl_d[i] = lvl_d;
    end

    // ========================================================
    // Bus clock divider
    logic [1:0] osc_cnt_q, osc_cnt_d;
    logic       e_clock_d;
    logic       e_end_q, e_end_d;
    logic       osc_rise;

    assign osc_rise = !pin_lvl[rnes_pkg::PIN_OSC] && pin_lvl_d[rnes_pkg::PIN_OSC];

    always_comb begin
        osc_cnt_d = osc_cnt_q;
        e_clock_d = e_clock_q;
        e_end_d   = 1'b0;
        if (osc_rise) begin
            osc_cnt_d = osc_cnt_q + 2'h1;
            e_clock_d = (osc_cnt_d >= rnes_pkg::OSC_CNT_E_HI);
            e_end_d   = (osc_cnt_d == 2'h0);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            osc_cnt_q <= 2'h0;
            e_clock_q <= 1'b0;
            e_end_q   <= 1'b0;
        end else begin
            osc_cnt_q <= osc_cnt_d;
            e_clock_q <= e_clock_d;
            e_end_q   <= e_end_d;
        end
    end

    // ========================================================
    // Entry sequencer
    rnes_pkg::rnes_state_t    state_q, state_d;
    rnes_pkg::rnes_cpu_regs_t regs_q, regs_d;
    rnes_pkg::rnes_bus_t      bus_d;
    logic [2:0]  step_q, step_d;
    logic [15:0] vec_q, vec_d;
    logic [7:0]  pc_hi_q, pc_hi_d;
    logic        from_reset_q, from_reset_d;
    logic [1:0]  clr_cnt_q, clr_cnt_d;
    logic        clr_acc_q, clr_acc_d;
    logic        nmi_pend_q, nmi_pend_d;
    logic        done_q, done_d;
    logic        seq_busy_d, pc_load_d, sp_load_d, irq_mask_d;
    logic [15:0] pc_value_d, sp_value_d;
    logic [2:0]  boot_cfg_d;
    logic        nmi_fall;
    logic        mask_clr_sw, mask_set_sw;
    logic [7:0]  push_byte;

    // A falling edge is remembered until serviced or a chip clear, so a pulse held low for two clocks or more is lost only to a chip clear
    assign nmi_fall = pin_lvl[rnes_pkg::PIN_NMI] && !pin_lvl_d[rnes_pkg::PIN_NMI];

    always_comb begin
        case (step_q)
            3'h0:    push_byte = regs_q.pc[7:0];
            3'h1:    push_byte = regs_q.pc[15:8];
            3'h2:    push_byte = regs_q.x[7:0];
            3'h3:    push_byte = regs_q.x[15:8];
            3'h4:    push_byte = regs_q.a;
            3'h5:    push_byte = regs_q.b;
            default: push_byte = regs_q.ccr;
        endcase
    end

    always_comb begin
        state_d      = state_q;
        regs_d       = regs_q;
        bus_d        = bus_q;
        step_d       = step_q;
        vec_d        = vec_q;
        pc_hi_d      = pc_hi_q;
        from_reset_d = from_reset_q;
        clr_cnt_d    = clr_cnt_q;
        clr_acc_d    = clr_acc_q;
        nmi_pend_d   = nmi_pend_q;
        done_d       = done_q || instr_done;
        seq_busy_d   = seq_busy_q;
        pc_load_d    = 1'b0;
        sp_load_d    = 1'b0;
        pc_value_d   = pc_value_q;
        sp_value_d   = sp_value_q;
        boot_cfg_d   = boot_cfg_q;
        irq_mask_d   = irq_mask_q;
        if (mask_clr_sw) begin
            irq_mask_d = 1'b0;
        end
        if (mask_set_sw) begin
            irq_mask_d = 1'b1;
        end
        // Clear must stay low through three bus cycle ends before it counts
        if (pin_lvl[rnes_pkg::PIN_CLR]) begin
            clr_cnt_d = 2'h0;
        end else if (e_end_q && clr_cnt_q != rnes_pkg::RST_MIN_BUSCYC) begin
            clr_cnt_d = clr_cnt_q + 2'h1;
        end
        if (clr_cnt_d == rnes_pkg::RST_MIN_BUSCYC) begin
            clr_acc_d = 1'b1;
        end
        if (clr_acc_q) begin
            state_d    = rnes_pkg::ST_HOLD;
            seq_busy_d = 1'b1;
            bus_d      = '0;
            done_d     = 1'b0;
            nmi_pend_d = 1'b0;
            if (pin_lvl[rnes_pkg::PIN_CLR]) begin
                clr_acc_d          = 1'b0;
                bus_d.addr[15:8]   = rnes_pkg::ADDR_HI_FORCE;
                boot_cfg_d         = {pin_lvl[rnes_pkg::PIN_CFG2],
                                      pin_lvl[rnes_pkg::PIN_CFG1],
                                      pin_lvl[rnes_pkg::PIN_CFG0]};
                irq_mask_d         = 1'b1;
                vec_d              = rnes_pkg::VEC_RESET;
                from_reset_d       = 1'b1;
                step_d             = rnes_pkg::STACK_BYTES;
                state_d            = rnes_pkg::ST_STACK;
            end
        end else begin
            if (nmi_fall) begin
                nmi_pend_d = 1'b1;
            end
            if (e_end_q) begin
                case (state_q)
                    rnes_pkg::ST_RUN: begin
                        // Decided only at a bus cycle boundary after the instruction ends
                        if (done_q && nmi_pend_q) begin
                            nmi_pend_d   = nmi_fall;
                            vec_d        = rnes_pkg::VEC_NMI;
                            regs_d       = cpu_regs;
                            from_reset_d = 1'b0;
                            step_d       = 3'h0;
                            seq_busy_d   = 1'b1;
                            state_d      = rnes_pkg::ST_STACK;
                        end else if (done_q && !pin_lvl[rnes_pkg::PIN_IRQ]
                                     && !irq_mask_q) begin
                            irq_mask_d   = 1'b1;
                            vec_d        = rnes_pkg::VEC_IRQ;
                            regs_d       = cpu_regs;
                            from_reset_d = 1'b0;
                            step_d       = 3'h0;
                            seq_busy_d   = 1'b1;
                            state_d      = rnes_pkg::ST_STACK;
                        end
                        done_d = instr_done;
                    end
                    rnes_pkg::ST_STACK: begin
                        if (step_q == rnes_pkg::STACK_BYTES) begin
                            bus_d.write = 1'b0;
                            bus_d.read  = 1'b1;
                            bus_d.addr  = vec_q;
                            state_d     = rnes_pkg::ST_VEC_HI;
                        end else begin
                            bus_d.write = 1'b1;
                            bus_d.read  = 1'b0;
                            bus_d.addr  = regs_q.sp - {13'h0000, step_q};
                            bus_d.wdata = push_byte;
                            step_d      = step_q + 3'h1;
                        end
                    end
                    rnes_pkg::ST_VEC_HI: begin
                        pc_hi_d    = bus_rdata;
                        bus_d.addr = vec_q + rnes_pkg::VEC_LO_STEP;
                        state_d    = rnes_pkg::ST_VEC_LO;
                    end
                    rnes_pkg::ST_VEC_LO: begin
                        pc_value_d = {pc_hi_q, bus_rdata};
                        pc_load_d  = 1'b1;
                        sp_value_d = regs_q.sp - rnes_pkg::STACK_BYTES_W;
                        sp_load_d  = !from_reset_q;
                        bus_d      = '0;
                        seq_busy_d = 1'b0;
                        done_d     = 1'b0;
                        state_d    = rnes_pkg::ST_RUN;
                    end
                    default: begin
                        bus_d      = '0;
                        seq_busy_d = 1'b0;
                        state_d    = rnes_pkg::ST_RUN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q      <= rnes_pkg::ST_RUN;
            regs_q       <= '0;
            bus_q        <= '0;
            step_q       <= 3'h0;
            vec_q        <= 16'h0000;
            pc_hi_q      <= 8'h00;
            from_reset_q <= 1'b0;
            clr_cnt_q    <= 2'h0;
            clr_acc_q    <= 1'b0;
            nmi_pend_q   <= 1'b0;
            done_q       <= 1'b0;
            seq_busy_q   <= 1'b0;
            pc_load_q    <= 1'b0;
            pc_value_q   <= 16'h0000;
            sp_load_q    <= 1'b0;
            sp_value_q   <= 16'h0000;
            boot_cfg_q   <= 3'h0;
            irq_mask_q   <= 1'b1;
        end else begin
            state_q      <= state_d;
            regs_q       <= regs_d;
            bus_q        <= bus_d;
            step_q       <= step_d;
            vec_q        <= vec_d;
            pc_hi_q      <= pc_hi_d;
            from_reset_q <= from_reset_d;
            clr_cnt_q    <= clr_cnt_d;
            clr_acc_q    <= clr_acc_d;
            nmi_pend_q   <= nmi_pend_d;
            done_q       <= done_d;
            seq_busy_q   <= seq_busy_d;
            pc_load_q    <= pc_load_d;
            pc_value_q   <= pc_value_d;
            sp_load_q    <= sp_load_d;
            sp_value_q   <= sp_value_d;
            boot_cfg_q   <= boot_cfg_d;
            irq_mask_q   <= irq_mask_d;
        end
    end

    // ========================================================
    // Register slave and standby RAM control
    logic [7:0]  ram_ctrl_q, ram_ctrl_d;
    logic        upper_lost_q, upper_lost_d;
    logic        ram_ok_d;
    logic [31:0] avs_readdata_d;
    logic        avs_waitrequest_d;
    logic        av_wr_take;
    logic        ram_en;
    logic        ram_upper;

    // Writes land on the edge where the master sees waitrequest low
    assign av_wr_take  = avs_write && !avs_waitrequest_q;
    assign mask_clr_sw = av_wr_take && avs_address == rnes_pkg::REG_CONTROL
                         && avs_writedata[rnes_pkg::CTL_MASK_CLR];
    assign mask_set_sw = av_wr_take && avs_address == rnes_pkg::REG_CONTROL
                         && avs_writedata[rnes_pkg::CTL_MASK_SET];
    assign ram_upper   = (ram_addr >= rnes_pkg::RAM_AW'(rnes_pkg::RAM_KEEP_BYTES));
    assign ram_en      = ram_req && ram_ctrl_q[rnes_pkg::RAM_E_BIT];

    always_comb begin
        ram_ctrl_d        = ram_ctrl_q;
        upper_lost_d      = upper_lost_q;
        ram_ok_d          = ram_en;
        avs_readdata_d    = avs_readdata_q;
        avs_waitrequest_d = 1'b1;
        if ((avs_read || avs_write) && avs_waitrequest_q) begin
            avs_waitrequest_d = 1'b0;
            avs_readdata_d    = 32'h0000_0000;
            case (avs_address)
                rnes_pkg::REG_RAM_CTRL: begin
                    avs_readdata_d[7:0] = ram_ctrl_q;
                end
                rnes_pkg::REG_STATUS: begin
                    avs_readdata_d[rnes_pkg::ST_MASK_BIT] = irq_mask_q;
                    avs_readdata_d[rnes_pkg::ST_NMI_BIT]  = nmi_pend_q;
                    avs_readdata_d[rnes_pkg::ST_BUSY_BIT] = seq_busy_q;
                    avs_readdata_d[rnes_pkg::ST_CFG_LSB +: 3] = boot_cfg_q;
                    avs_readdata_d[rnes_pkg::ST_LOST_BIT] = upper_lost_q;
                end
                default: begin
                    avs_readdata_d = 32'h0000_0000;
                end
            endcase
        end
        if (av_wr_take && avs_address == rnes_pkg::REG_RAM_CTRL) begin
            ram_ctrl_d[rnes_pkg::RAM_E_BIT] = avs_writedata[rnes_pkg::RAM_E_BIT];
        end
        // Upper half content is void after power down until the next chip clear
        if (clr_acc_q) begin
            upper_lost_d = 1'b0;
        end
        if (standby_power_down) begin
            upper_lost_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ram_ctrl_q        <= rnes_pkg::RAM_CTRL_RESET;
            upper_lost_q      <= 1'b0;
            ram_ok_q          <= 1'b0;
            avs_readdata_q    <= 32'h0000_0000;
            avs_waitrequest_q <= 1'b1;
        end else begin
            ram_ctrl_q        <= ram_ctrl_d;
            upper_lost_q      <= upper_lost_d;
            ram_ok_q          <= ram_ok_d;
            avs_readdata_q    <= avs_readdata_d;
            avs_waitrequest_q <= avs_waitrequest_d;
        end
    end

    rnes_standby_ram #(
        .DEPTH (rnes_pkg::RAM_BYTES),
        .AW    (rnes_pkg::RAM_AW)
    ) u_ram (
        .clock   (clock),
        .en      (ram_en),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (ram_wdata),
        .zero_rd (upper_lost_q && ram_upper),
        .rdata_q (ram_rdata)
    );
endmodule : rnes_sequencer

// ===== rtl/rnes_standby_ram.sv
`timescale 1ns/1ps
// ============================================================
// Standby RAM, registered read
module rnes_standby_ram #(
    parameter int unsigned DEPTH = 128,
    parameter int unsigned AW    = 7
) (
    // Clock
    input  wire logic          clock,
    // Access
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic          zero_rd,
    output logic      [7:0]    rdata_q
);
    // Every entry must be reachable by the address width
    if (DEPTH > (1 << AW)) begin : g_bad_depth
        $error("depth exceeds address range");
    end

    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (en && !we) begin
            rdata_d = zero_rd ? 8'h00 : mem[addr];
        end
    end

    // Contents carry no reset: retention across a chip clear is the point
    always_ff @(posedge clock) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= rdata_d;
    end
endmodule : rnes_standby_ram

// ===== tb/reset_nmi_entry_sequencer_bench.sv
`timescale 1ns/1ps
module reset_nmi_entry_sequencer_bench;
    logic clock = 0, reset = 1, osc_input = 0, chip_clear_in_n = 0, nmi_n = 1, irq_n = 1;
    logic boot_config_bit2 = 0, boot_config_bit1 = 0, boot_config_bit0 = 0, instr_done = 0;
    logic standby_power_down = 0, ram_req = 0, ram_we = 0, avs_read = 0, avs_write = 0;
    logic e_clock_q, seq_busy_q, pc_load_q, sp_load_q, irq_mask_q, ram_ok_q, avs_waitrequest_q;
    logic [2:0] boot_cfg_q, cfg;
    logic [6:0] ram_addr = 7'h00;
    logic [7:0] bus_rdata, ram_wdata = 8'h00, ram_rdata, avs_address = 8'h00;
    logic [15:0] pc_value_q, sp_value_q;
    logic [31:0] avs_writedata = 32'h0, avs_readdata_q, rd, r, seed = 32'h9B9745B2;
    rnes_pkg::rnes_cpu_regs_t cpu_regs = '0;
    rnes_pkg::rnes_bus_t bus_q;
    int n_errors = 0, check_count = 0, cyc = 0, osc_n = 0;
    rnes_sequencer i_dut (.*);
    rnes_mem_model i_mem (.*);
    always #10 clock = ~clock;
    // ==========
    // Oscillator at 5 MHz and run limit
    always @(posedge clock) begin
        osc_n <= (osc_n == 4) ? 0 : osc_n + 1;
        if (osc_n == 4) osc_input <= ~osc_input;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            stop_test;
        end
    end
    task stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task av(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        do @(posedge clock); while (avs_waitrequest_q !== 1'b0);
        rd = avs_readdata_q;
        {avs_write, avs_read} <= 2'b00;
    endtask : av
    task wait_pc(input logic [15:0] v);
        do @(posedge clock); while (pc_load_q !== 1'b1);
        chk(pc_value_q, {~v[7:0], ~(v[7:0] + 8'h01)}, "pc");
        chk(sp_load_q, v != 16'hFFFE, "spload");
    endtask : wait_pc
    function automatic logic [7:0] push_exp(input int k);
        logic [55:0] v;
        v = {cpu_regs.ccr, cpu_regs.b, cpu_regs.a, cpu_regs.x, cpu_regs.pc};
        return v[k*8 +: 8];
    endfunction : push_exp
    task pulse;
        @(posedge clock) instr_done <= 1;
        @(posedge clock) instr_done <= 0;
    endtask : pulse
    task ram(input logic we, input logic [6:0] a, input logic [7:0] d);
        @(posedge clock) {ram_req, ram_we, ram_addr, ram_wdata} <= {1'b1, we, a, d};
        @(posedge clock) ram_req <= 0;
        #1;
    endtask : ram
    initial begin
        r = $random(seed);
        cfg = r[2:0];
        repeat (6) @(posedge clock);
        reset <= 0;
        {boot_config_bit2, boot_config_bit1, boot_config_bit0} <= cfg;
        cpu_regs <= {$random(seed), $random(seed), 16'($random(seed))};
        av(0, 8'h14, 0);
        chk(rd, 32'h40, "ramctl");
        repeat (160) @(posedge clock);
        chip_clear_in_n <= 1;
        wait_pc(16'hFFFE);
        chk(boot_cfg_q, cfg, "cfg");
        chk(irq_mask_q, 1, "mask");
        $display("test clear done");
        nmi_n <= 0;
        pulse;
        wait_pc(16'hFFFC);
        chk(sp_value_q, cpu_regs.sp - 16'h0007, "sp");
        for (int k = 0; k < 7; k++) begin
            chk(i_mem.stk[3'(cpu_regs.sp - k)], push_exp(k), "stack");
        end
        irq_n <= 0;
        pulse;
        repeat (100) @(posedge clock);
        chk(seq_busy_q, 0, "busy");
        av(1, 8'h1C, 1);
        av(0, 8'h18, 0);
        chk(rd[0], 0, "stat");
        pulse;
        wait_pc(16'hFFF8);
        chk(irq_mask_q, 1, "irqmask");
        {irq_n, nmi_n} <= 2'b11;
        $display("test irq done");
        av(1, 8'h14, 0);
        ram(1, 7'h05, r[15:8]);
        chk(ram_ok_q, 0, "off");
        av(1, 8'h14, 32'h40);
        ram(1, 7'h05, r[15:8]);
        ram(1, 7'h46, r[23:16]);
        @(posedge clock) standby_power_down <= 1;
        @(posedge clock) standby_power_down <= 0;
        ram(0, 7'h05, 0);
        chk(ram_rdata, r[15:8], "low");
        chk(ram_ok_q, 1, "on");
        ram(0, 7'h46, 0);
        chk(ram_rdata, 0, "high");
        av(0, 8'h20, 0);
        chk(rd, 0, "unmapped");
        $display("test ram done");
        stop_test;
    end
endmodule : reset_nmi_entry_sequencer_bench

// ===== tb/rnes_checker.sv
`timescale 1ns/1ps
// ==========
// Port checker
module rnes_checker (
    // Clock and reset
    input wire logic                clock,
    input wire logic                reset,
    // Sequencer outputs
    input wire logic                e_clock_q,
    input wire logic                seq_busy_q,
    input wire logic                pc_load_q,
    input wire logic                irq_mask_q,
    input wire logic                sp_load_q,
    input wire rnes_pkg::rnes_bus_t bus_q,
    // Standby RAM and register bus
    input wire logic                ram_req,
    input wire logic                ram_ok_q,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic                avs_waitrequest_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    mask_on_reset_a: assert property ($fell(reset) |-> irq_mask_q) else $error("mask");
    vec_read_hi_a: assert property (bus_q.read |-> bus_q.addr[15:8] == 8'hFF) else $error("hi");
    stack_owned_a: assert property (bus_q.write |-> seq_busy_q) else $error("stack");
    e_high_len_a: assert property ($rose(e_clock_q) |=> e_clock_q [*8]) else $error("eh");
    e_low_len_a: assert property ($fell(e_clock_q) |=> !e_clock_q [*8]) else $error("el");
    ram_ok_cause_a: assert property (ram_ok_q |-> $past(ram_req)) else $error("ram");
    av_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest_q
        |=> !avs_waitrequest_q) else $error("wait");
    av_wait_pulse_a: assert property (!avs_waitrequest_q |=> avs_waitrequest_q) else $error("wp");
    pc_pulse_a: assert property (pc_load_q |=> !pc_load_q) else $error("pc");
    bus_excl_a: assert property (!(bus_q.read && bus_q.write)) else $error("rw");
    cover property (pc_load_q);
    cover property (sp_load_q);
    cover property (ram_ok_q);
endmodule : rnes_checker
bind rnes_sequencer rnes_checker i_chk (.*);

// ===== tb/rnes_mem_model.sv
`timescale 1ns/1ps
// ==========
// Vector memory: each byte is the inverted low address byte
module rnes_mem_model (
    // Clock
    input  wire logic                clock,
    // Bus
    input  wire rnes_pkg::rnes_bus_t bus_q,
    output logic [7:0]               bus_rdata
);
    logic [7:0] noise_q = 8'hA5;
    logic [7:0] stk [8];
    // Pushed bytes kept by low address bits, enough for one seven-byte frame
    always_ff @(posedge clock) if (bus_q.write) stk[bus_q.addr[2:0]] <= bus_q.wdata;
    // Idle data toggles so a late sample never sees stale bytes
    always_ff @(posedge clock) noise_q <= ~noise_q;
    assign bus_rdata = bus_q.read ? ~bus_q.addr[7:0] : noise_q;
endmodule : rnes_mem_model
